// ### rtl/scw_pkg.sv
// Summary of operation
// R01 - Select 100 holds threshold, delay, supply, wake, fallback
// R02 - Unchanged settings keep their default values
// R03 - Selected register contents return on serial output
// R04 - Wake pin enable defaults 1, gates pin wake
// R05 - Fallback bit defaults 0, device sets it
// R06 - Cyclic wake enable defaults 0, 1 activates
// R07 - Fail-count bit picks one or two failures
// R08 - Select 101 slope bit defaults 1, low slope
// R09 - CAN mode field defaults 00, four states
// R10 - LIN mode field defaults 00, four states
// R11 - Select 110 type and enable default 1
// R12 - Controller writes reserved watchdog bit as 1
// R13 - Bad watchdog checksum keeps previous valid state
// R14 - Select 111 is read-only diagnosis
// R15 - Threshold code 00 rejected, previous kept
// R16 - Threshold one is the initial setting
// R17 - Codes 0-15 give (code+1) times 16 ms
// R18 - Codes 16-31 give code*48-464 ms
// R19 - Restart reason 00 none/fallback, 01 undervoltage
// R20 - Reason 10 first watchdog failure or cyclic
// R21 - Reason 11 serial restart or external reset
// R22 - Read-only read of diagnosis clears reason
// R23 - Sleep or fail-safe exit clears reason
// R24 - Read-only writes nothing, clears, triggers watchdog
// R25 - Read-only answers same frame, others next
// R26 - Reset loads every default before access
// R27 - Writes to select 111 change nothing
package scw_pkg;
    // Serial frame, least significant bit first
    localparam int FRAME_BITS = 16;
    localparam int MODE_LSB = 0;
    localparam int SEL_LSB = 3;
    localparam int DATA_LSB = 6;
    localparam int DATA_BITS = 10;
    localparam logic [2:0] MODE_READ_ONLY = 3'h7;
    localparam logic [2:0] SEL_GENERAL = 3'h4;
    localparam logic [2:0] SEL_XCVR = 3'h5;
    localparam logic [2:0] SEL_WDOG = 3'h6;
    localparam logic [2:0] SEL_DIAG = 3'h7;
    localparam logic [2:0] PREV_SEL_RST = SEL_GENERAL;

    typedef enum logic [1:0] {
        SCW_CELL_OFF, SCW_CELL_WAKE, SCW_CELL_RX_ONLY, SCW_CELL_NORMAL
    } scw_cell_mode_t;

    typedef struct packed {
        logic wdog_fail_count_to_fallback;
        logic cyclic_wake_enable;
        logic fallback_output_ctl;
        logic second_supply_enable;
        logic wake_pin_enable;
        logic third_supply_enable;
        logic reset_delay_long;
        logic [1:0] reset_threshold_sel;
    } scw_general_t;

    typedef struct packed {
        scw_cell_mode_t lin_cell_mode;
        scw_cell_mode_t can_cell_mode;
        logic lin_slope_sel;
    } scw_xcvr_t;

    typedef struct packed {
        logic wdog_parity_bit;
        logic wdog_enable;
        logic wdog_reserved;
        logic wdog_type_sel;
        logic [4:0] wdog_period;
    } scw_wdog_t;

    localparam scw_general_t GENERAL_RST = 9'h115;
    localparam scw_xcvr_t XCVR_RST = 5'h01;
    localparam scw_wdog_t WDOG_RST = 9'h1ef;
    localparam logic [1:0] THRESH_INVALID = 2'h0;

    localparam logic [1:0] RR_NONE = 2'h0;
    localparam logic [1:0] RR_UNDERVOLT = 2'h1;
    localparam logic [1:0] RR_WDOG = 2'h2;
    localparam logic [1:0] RR_SPI = 2'h3;

    // Watchdog period encoding, in ms
    localparam int WDOG_BASE_MS = 16;
    localparam int WDOG_SLOPE_MS = 48;
    localparam int WDOG_OFFSET_MS = 464;
    localparam logic [4:0] WDOG_SPLIT_CODE = 5'h10;
endpackage

// ### rtl/scw_spi_rx.sv
`timescale 1ns/1ns
`default_nettype none
module scw_spi_rx #(
    parameter int FRAME_BITS = scw_pkg::FRAME_BITS
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial pins
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Frame side
    input wire logic [FRAME_BITS-1:0] tx_word,
    output logic [FRAME_BITS-1:0] rx_bits,
    output logic [4:0] bit_cnt,
    output logic frame_done
);
    typedef struct packed {
        logic [2:0] clk_q;
        logic [2:0] cs_q;
        logic [1:0] sdi_q;
        logic [FRAME_BITS-1:0] shreg;
        logic [4:0] cnt;
        logic sdo;
        logic oe;
        logic done;
    } scw_spi_st_t;

    scw_spi_st_t st, next_st;
    logic rise, fall, start, stop;

    always_comb begin
        next_st = st;
        next_st.clk_q = {st.clk_q[1:0], spi_clk};
        next_st.cs_q = {st.cs_q[1:0], spi_cs_n};
        next_st.sdi_q = {st.sdi_q[0], spi_sdi};
        next_st.done = 1'b0;
        rise = st.clk_q[1] & ~st.clk_q[2] & ~st.cs_q[1];
        fall = ~st.clk_q[1] & st.clk_q[2] & ~st.cs_q[1];
        start = ~st.cs_q[1] & st.cs_q[2];
        stop = st.cs_q[1] & ~st.cs_q[2];
        if (start) begin
            next_st.cnt = 5'h0;
            next_st.oe = 1'b1;
            next_st.sdo = tx_word[0];
        end else if (stop) begin
            next_st.oe = 1'b0;
            // Only complete frames count
            next_st.done = (st.cnt == 5'(FRAME_BITS));
        end else if (rise && st.cnt < 5'(FRAME_BITS)) begin
            next_st.shreg[st.cnt[3:0]] = st.sdi_q[1];
            next_st.cnt = st.cnt + 5'h1;
        end else if (fall && st.cnt < 5'(FRAME_BITS)) begin
            next_st.sdo = tx_word[st.cnt[3:0]];
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
            // Select idles high, so no false frame edge after reset
            st.cs_q <= 3'h7;
        end else begin
            st <= next_st;
        end
    end

    assign spi_sdo = st.sdo;
    assign spi_sdo_oe = st.oe;
    assign rx_bits = st.shreg;
    assign bit_cnt = st.cnt;
    assign frame_done = st.done;
endmodule
`default_nettype wire

// ### rtl/scw_wdog_period.sv
`timescale 1ns/1ns
`default_nettype none
module scw_wdog_period (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Code in, period out
    input wire logic [4:0] code,
    output logic [10:0] period_ms
);
    typedef struct packed {
        logic [10:0] ms;
    } scw_per_st_t;

    scw_per_st_t st, next_st;
    logic [11:0] wide;

    always_comb begin
        next_st = st;
        if (code < scw_pkg::WDOG_SPLIT_CODE) begin
            wide = ({7'h0, code} + 12'h1)
                * 12'(scw_pkg::WDOG_BASE_MS); // R17
        end else begin
            wide = {7'h0, code} * 12'(scw_pkg::WDOG_SLOPE_MS)
                - 12'(scw_pkg::WDOG_OFFSET_MS); // R18
        end
        next_st.ms = wide[10:0];
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign period_ms = st.ms;
endmodule
`default_nettype wire

// ### rtl/scw_regs.sv
`timescale 1ns/1ns
`default_nettype none
module scw_regs (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial pins
    input wire logic spi_clk,
    input wire logic spi_cs_n,
    input wire logic spi_sdi,
    output logic spi_sdo,
    output logic spi_sdo_oe,
    // Device status and events
    input wire logic [2:0] mode_status,
    input wire logic wake_pin_event,
    input wire logic fallback_entry,
    input wire logic wdog_fail,
    input wire logic wdog_ok,
    input wire logic undervolt_restart,
    input wire logic wdog_first_fail_restart,
    input wire logic cyclic_wake_unack,
    input wire logic spi_restart,
    input wire logic ext_reset_low,
    input wire logic exit_sleep_or_failsafe,
    input wire logic [2:0] fallback_reason,
    input wire logic [2:0] test_pin_cfg,
    // Configuration outputs
    output scw_pkg::scw_general_t general,
    output scw_pkg::scw_xcvr_t xcvr,
    output scw_pkg::scw_wdog_t wdog,
    output logic [10:0] wdog_period_ms,
    output logic [1:0] restart_reason,
    // Pulses
    output logic wake_req,
    output logic wdog_trigger,
    output logic mode_cmd_valid,
    output logic [2:0] mode_cmd
);
    typedef struct packed {
        scw_pkg::scw_general_t general;
        scw_pkg::scw_xcvr_t xcvr;
        scw_pkg::scw_wdog_t wdog;
        logic [1:0] rr;
        logic [2:0] prev_sel;
        logic fail_seen;
        logic wake;
        logic trig;
        logic cmd_valid;
        logic [2:0] cmd;
    } scw_st_t;

    localparam int FB = scw_pkg::FRAME_BITS;
    localparam int DB = scw_pkg::DATA_BITS;

    scw_st_t st, next_st;

    logic [FB-1:0] rx_bits;
    logic [FB-1:0] tx_word;
    logic [4:0] bit_cnt;
    logic frame_done;
    logic [2:0] f_mode;
    logic [2:0] f_sel;
    logic [DB-1:0] f_data;
    logic is_ro;
    logic live_ro;
    logic [DB-1:0] tx_data;
    logic [DB-1:0] rd_live;
    logic [DB-1:0] rd_prev;

    scw_spi_rx #(
        .FRAME_BITS(FB)
    ) u_spi (
        .mclk(mclk),
        .rst(rst),
        .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n),
        .spi_sdi(spi_sdi),
        .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe),
        .tx_word(tx_word),
        .rx_bits(rx_bits),
        .bit_cnt(bit_cnt),
        .frame_done(frame_done)
    );

    scw_wdog_period u_period (
        .mclk(mclk),
        .rst(rst),
        .code(st.wdog.wdog_period),
        .period_ms(wdog_period_ms)
    );

    // Read view of one select code
    function automatic logic [DB-1:0] read_sel(
        input logic [2:0] sel,
        input scw_st_t s
    );
        logic [DB-1:0] v;
        v = '0;
        if (sel == scw_pkg::SEL_GENERAL) begin
            v = {1'b0, s.general};
        end else if (sel == scw_pkg::SEL_XCVR) begin
            v = {5'h0, s.xcvr};
        end else if (sel == scw_pkg::SEL_WDOG) begin
            v = {1'b0, s.wdog};
        end else if (sel == scw_pkg::SEL_DIAG) begin
            // Diagnosis only, never stored from a write
            v = {2'h0, test_pin_cfg, fallback_reason, s.rr}; // R14
        end
        return v;
    endfunction

    // Frame field split
    assign f_mode = rx_bits[scw_pkg::MODE_LSB +: 3];
    assign f_sel = rx_bits[scw_pkg::SEL_LSB +: 3];
    assign f_data = rx_bits[scw_pkg::DATA_LSB +: DB];
    assign is_ro = (f_mode == scw_pkg::MODE_READ_ONLY);

    // Answer word on the serial output
    assign live_ro = is_ro && (bit_cnt >= 5'(scw_pkg::DATA_LSB));
    // A process, so the diagnosis pins read inside the function wake it
    always_comb begin
        rd_live = read_sel(f_sel, st);
        rd_prev = read_sel(st.prev_sel, st);
        if (live_ro) begin
            tx_data = rd_live; // R25
        end else begin
            tx_data = rd_prev; // R03 R25
        end
    end

    assign tx_word = {tx_data, st.prev_sel, mode_status};

    always_comb begin
        scw_pkg::scw_general_t ng;
        scw_pkg::scw_wdog_t nw;
        logic fb_set;
        ng = f_data[8:0];
        nw = f_data[8:0];
        fb_set = 1'b0;
        // Unwritten fields simply hold their current values
        next_st = st; // R02
        next_st.trig = 1'b0;
        next_st.cmd_valid = 1'b0;
        next_st.wake = wake_pin_event
            & st.general.wake_pin_enable; // R04

        if (frame_done) begin
            next_st.prev_sel = f_sel;
            if (is_ro) begin
                // No write, no mode change
                next_st.trig = 1'b1; // R24
                if (f_sel == scw_pkg::SEL_DIAG) begin
                    next_st.rr = scw_pkg::RR_NONE; // R22 R24
                end
            end else begin
                next_st.cmd_valid = 1'b1;
                next_st.cmd = f_mode;
                if (f_sel == scw_pkg::SEL_GENERAL) begin
                    // Select 100 layout
                    if (ng.reset_threshold_sel
                            == scw_pkg::THRESH_INVALID) begin
                        ng.reset_threshold_sel =
                            st.general.reset_threshold_sel; // R15
                    end
                    next_st.general = ng; // R01 R06
                end else if (f_sel == scw_pkg::SEL_XCVR) begin
                    next_st.xcvr = f_data[4:0]; // R08 R09 R10
                end else if (f_sel == scw_pkg::SEL_WDOG) begin
                    if (^f_data[7:0] == f_data[8]) begin // R13
                        // Reserved bit is held at one
                        nw.wdog_reserved = 1'b1; // R12
                        nw.wdog_parity_bit = ^{nw.wdog_enable,
                            1'b1, nw.wdog_type_sel,
                            nw.wdog_period};
                        next_st.wdog = nw; // R11
                        next_st.trig = 1'b1;
                    end
                end
                // Select 111 takes no write data
            end // R27
        end

        // Watchdog failures toward the fallback output
        if (wdog_ok) begin
            next_st.fail_seen = 1'b0;
        end
        if (wdog_fail) begin
            if (!st.general.wdog_fail_count_to_fallback
                    || st.fail_seen) begin
                fb_set = 1'b1; // R07
                next_st.fail_seen = 1'b0;
            end else begin
                next_st.fail_seen = 1'b1; // R07
            end
        end
        if (fallback_entry) begin
            fb_set = 1'b1;
        end
        // Hardware set wins over a same-cycle clear
        if (fb_set) begin
            next_st.general.fallback_output_ctl = 1'b1; // R05
        end

        // Restart reason: clears first, then events win
        if (exit_sleep_or_failsafe) begin
            next_st.rr = scw_pkg::RR_NONE; // R23
        end
        if (fb_set) begin
            next_st.rr = scw_pkg::RR_NONE; // R19
        end
        if (spi_restart || ext_reset_low) begin
            next_st.rr = scw_pkg::RR_SPI; // R21
        end else if (wdog_first_fail_restart
                || cyclic_wake_unack) begin
            next_st.rr = scw_pkg::RR_WDOG; // R20
        end else if (undervolt_restart) begin
            next_st.rr = scw_pkg::RR_UNDERVOLT; // R19
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st.general <= scw_pkg::GENERAL_RST; // R16 R26
            st.xcvr <= scw_pkg::XCVR_RST; // R26
            st.wdog <= scw_pkg::WDOG_RST; // R26
            st.rr <= scw_pkg::RR_NONE;
            st.prev_sel <= scw_pkg::PREV_SEL_RST;
            st.fail_seen <= 1'b0;
            st.wake <= 1'b0;
            st.trig <= 1'b0;
            st.cmd_valid <= 1'b0;
            st.cmd <= 3'h0;
        end else begin
            st <= next_st;
        end
    end

    assign general = st.general;
    assign xcvr = st.xcvr;
    assign wdog = st.wdog;
    assign restart_reason = st.rr;
    assign wake_req = st.wake;
    assign wdog_trigger = st.trig;
    assign mode_cmd_valid = st.cmd_valid;
    assign mode_cmd = st.cmd;
endmodule
`default_nettype wire

// ### verification/scw_regs_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module scw_regs_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Events
    input wire logic wake_pin_event,
    input wire logic fallback_entry,
    input wire logic wdog_first_fail_restart,
    input wire logic cyclic_wake_unack,
    input wire logic spi_restart,
    input wire logic ext_reset_low,
    // Outputs
    input wire scw_pkg::scw_general_t general,
    input wire scw_pkg::scw_wdog_t wdog,
    input wire logic [10:0] wdog_period_ms,
    input wire logic [1:0] restart_reason,
    input wire logic wake_req,
    input wire logic wdog_trigger
);
    logic up;
    wire logic hi = spi_restart | ext_reset_low;
    wire logic mid = wdog_first_fail_restart | cyclic_wake_unack;
    // Masks the first edge after reset, where $past still sees reset
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            up <= 1'b0;
        end else begin
            up <= 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    property p_wake;
        up |-> wake_req == $past(wake_pin_event && general.wake_pin_enable);
    endproperty
    a_wake: assert property (p_wake) else $error("bad wake");
    property p_fb;
        fallback_entry |-> ##[1:2] general.fallback_output_ctl;
    endproperty
    a_fb: assert property (p_fb) else $error("no fallback");
    property p_thr;
        general.reset_threshold_sel != 2'h0;
    endproperty
    a_thr: assert property (p_thr) else $error("threshold 00");
    property p_par;
        wdog.wdog_reserved && wdog.wdog_parity_bit == ^wdog[7:0];
    endproperty
    a_par: assert property (p_par) else $error("bad parity");
    property p_plo;
        up && $past(wdog.wdog_period) < 5'h10
            |-> wdog_period_ms == ($past(wdog.wdog_period) + 11'h1) * 11'h10;
    endproperty
    a_plo: assert property (p_plo) else $error("bad period");
    property p_phi;
        up && $past(wdog.wdog_period) >= 5'h10
            |-> wdog_period_ms == $past(wdog.wdog_period) * 11'h30 - 11'h1d0;
    endproperty
    a_phi: assert property (p_phi) else $error("bad period");
    property p_rhi;
        hi |=> restart_reason == 2'h3;
    endproperty
    a_rhi: assert property (p_rhi) else $error("reason not 3");
    property p_rmid;
        mid && !hi |=> restart_reason == 2'h2;
    endproperty
    a_rmid: assert property (p_rmid) else $error("reason not 2");
    c_wake: cover property (wake_req);
    c_trig: cover property (wdog_trigger);
    c_rhi: cover property (restart_reason == 2'h3);
endmodule
`default_nettype wire

// ### verification/scw_spi_master.sv
`timescale 1ns/1ns
`default_nettype none
module scw_spi_master (
    // Clock
    input wire logic mclk,
    // Serial pins
    output logic spi_clk,
    output logic spi_cs_n,
    output logic spi_sdi,
    input wire logic spi_sdo
);
    initial begin
        spi_clk = 1'b0;
        spi_cs_n = 1'b1;
        spi_sdi = 1'b0;
    end
    // One frame, least significant bit first; clock idles low
    task automatic xfer(input logic [15:0] w, input int hp,
        output logic [15:0] r);
        @(negedge mclk);
        spi_cs_n = 1'b0;
        repeat (hp) @(negedge mclk);
        for (int i = 0; i < 16; i++) begin
            spi_sdi = w[i];
            repeat (hp) @(negedge mclk);
            spi_clk = 1'b1;
            r[i] = spi_sdo;
            repeat (hp) @(negedge mclk);
            spi_clk = 1'b0;
        end
        repeat (hp) @(negedge mclk);
        spi_cs_n = 1'b1;
        // Released data line flips so stale data never looks valid
        spi_sdi = ~spi_sdi;
    endtask
endmodule
`default_nettype wire

// ### verification/scw_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module scw_regs_test;
    localparam logic [2:0] RO = scw_pkg::MODE_READ_ONLY;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] mode_status = 3'h0;
    logic [2:0] fb_why = 3'h0;
    logic [2:0] tpin = 3'h0;
    logic [9:0] ev = 10'h0;
    wire logic spi_clk, spi_cs_n, spi_sdi;
    logic spi_sdo, spi_sdo_oe, wake_req, wdog_trigger, mode_cmd_valid;
    logic [2:0] mode_cmd, prev;
    logic [10:0] wdog_period_ms;
    logic [1:0] restart_reason, err;
    scw_pkg::scw_general_t general, eg;
    scw_pkg::scw_xcvr_t xcvr, ex;
    scw_pkg::scw_wdog_t wdog, ew;
    logic [15:0] lf = 16'h44f4;
    int checked = 0;
    int fail_count = 0;
    int cyc = 0;

    always #25 mclk = ~mclk;

    scw_spi_master m0 (.mclk(mclk), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo));
    scw_regs dut (.mclk(mclk), .rst(rst), .spi_clk(spi_clk),
        .spi_cs_n(spi_cs_n), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .mode_status(mode_status),
        .wake_pin_event(ev[0]), .fallback_entry(ev[1]),
        .wdog_fail(ev[2]), .wdog_ok(ev[3]), .undervolt_restart(ev[4]),
        .wdog_first_fail_restart(ev[5]), .cyclic_wake_unack(ev[6]),
        .spi_restart(ev[7]), .ext_reset_low(ev[8]),
        .exit_sleep_or_failsafe(ev[9]), .fallback_reason(fb_why),
        .test_pin_cfg(tpin), .general(general), .xcvr(xcvr),
        .wdog(wdog), .wdog_period_ms(wdog_period_ms),
        .restart_reason(restart_reason), .wake_req(wake_req),
        .wdog_trigger(wdog_trigger), .mode_cmd_valid(mode_cmd_valid),
        .mode_cmd(mode_cmd));

    function automatic logic [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic logic [9:0] rd(input logic [2:0] s);
        case (s)
            3'h4: return {1'b0, eg};
            3'h5: return {5'h0, ex};
            3'h6: return {1'b0, ew};
            3'h7: return {2'h0, tpin, fb_why, err};
            default: return 10'h0;
        endcase
    endfunction
    function automatic logic [10:0] per_ms(input logic [4:0] c);
        if (c < 5'h10) return (11'(c) + 11'h1) * 11'h10;
        return 11'(c) * 11'h30 - 11'h1d0;
    endfunction

    task automatic summarize();
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_all();
        chk(general, eg);
        chk(xcvr, ex);
        chk(wdog, ew);
        chk(restart_reason, err);
        chk(wdog_period_ms, per_ms(ew.wdog_period));
    endtask
    task automatic pulse(input int i);
        ev[i] = 1'b1;
        @(negedge mclk);
        ev[i] = 1'b0;
        repeat (4) @(negedge mclk);
    endtask
    task automatic frame(input logic [2:0] m, input logic [2:0] s,
        input logic [9:0] d);
        logic [15:0] r;
        logic [2:0] a;
        int hp;
        logic seen_v, seen_t;
        r = rnd();
        {mode_status, fb_why, tpin} = r[8:0];
        hp = 4 + int'(r[15:14]);
        a = (m == RO) ? s : prev;
        m0.xfer({d, s, m}, hp, r);
        chk(spi_sdo_oe, 1'b1);
        chk(r, {rd(a), prev, mode_status});
        if (m == RO && s == 3'h7) err = 2'h0;
        if (m != RO && s == 3'h4)
            eg = (d[1:0] == 2'h0) ? {d[8:2], eg[1:0]} : d[8:0];
        if (m != RO && s == 3'h5) ex = d[4:0];
        if (m != RO && s == 3'h6 && d[8] == ^d[7:0]) ew = d[8:0];
        prev = s;
        seen_v = 1'b0;
        seen_t = 1'b0;
        repeat (8) begin
            @(negedge mclk);
            seen_v |= mode_cmd_valid;
            seen_t |= wdog_trigger;
        end
        chk(spi_sdo_oe, 1'b0);
        chk(seen_v, m != RO);
        if (m != RO) chk(mode_cmd, m);
        chk(seen_t, m == RO || (s == 3'h6 && d[8] == ^d[7:0]));
        cmp_all();
    endtask

    initial begin
        logic [15:0] r;
        logic [9:0] d;
        repeat (6) @(negedge mclk);
        rst = 1'b0;
        eg = 9'h115;
        ex = 5'h01;
        ew = 9'h1ef;
        err = 2'h0;
        prev = 3'h4;
        repeat (2) @(negedge mclk);
        cmp_all();
        for (int i = 0; i < 8; i++) frame(RO, 3'(i), 10'h3ff);
        frame(3'h1, 3'h4, 10'h0ec);
        repeat (30) begin
            r = rnd();
            d = r[15:6];
            if (r[1:0] == 2'h2) begin
                d[9] = 1'b0;
                d[6] = 1'b1;
                d[8] = ^d[7:0] ^ (r[5] & r[4]);
            end
            frame(r[4:2], {1'b1, r[1:0]}, d);
        end
        frame(3'h1, 3'h6, 10'h1ef);
        frame(3'h1, 3'h4, 10'h111);
        pulse(3);
        pulse(2);
        cmp_all();
        pulse(2);
        eg.fallback_output_ctl = 1'b1;
        cmp_all();
        frame(3'h1, 3'h4, 10'h011);
        pulse(2);
        eg.fallback_output_ctl = 1'b1;
        cmp_all();
        for (int i = 4; i < 9; i++) begin
            pulse(i);
            err = (i == 4) ? 2'h1 : (i < 7) ? 2'h2 : 2'h3;
            frame(RO, 3'h7, 10'h0);
        end
        pulse(7);
        pulse(9);
        err = 2'h0;
        cmp_all();
        frame(3'h1, 3'h4, 10'h011);
        pulse(4);
        pulse(1);
        eg.fallback_output_ctl = 1'b1;
        cmp_all();
        for (int k = 0; k < 2; k++) begin
            ev[0] = 1'b1;
            @(negedge mclk);
            ev[0] = 1'b0;
            chk(wake_req, eg.wake_pin_enable);
            frame(3'h1, 3'h4, 10'h001);
        end
        summarize();
    end

    always @(posedge mclk) begin
        cyc++;
        if (cyc == 40000) begin
            fail_count++;
            summarize();
        end
    end
endmodule

bind scw_regs scw_regs_assertions chk_i (.mclk(mclk), .rst(rst),
    .wake_pin_event(wake_pin_event), .fallback_entry(fallback_entry),
    .wdog_first_fail_restart(wdog_first_fail_restart),
    .cyclic_wake_unack(cyclic_wake_unack), .spi_restart(spi_restart),
    .ext_reset_low(ext_reset_low), .general(general), .wdog(wdog),
    .wdog_period_ms(wdog_period_ms), .restart_reason(restart_reason),
    .wake_req(wake_req), .wdog_trigger(wdog_trigger));
`default_nettype wire
